// file: shared/dbsp_pkg.sv
/*
 package for the ddr burst-of-two static memory port: widths, lane layout, lock and clocking counts.
 assumes both ends and the link interface import it.
*/
package dbsp_pkg;
	localparam int DBSP_DATA_W = 36;
	localparam int DBSP_NARROW_W = 18;
	localparam int DBSP_LANE_W = 9;
	localparam int DBSP_MASK_W = 4;
	localparam int DBSP_NARROW_MASK_W = 2;
	localparam int DBSP_ADDR_W = 19;
	localparam int DBSP_BURST_LEN = 2;
	localparam int DBSP_DLL_LOCK_CYC = 2048;
	localparam int DBSP_LOCK_CNT_W = 12;
	localparam int DBSP_BYPASS_MAX_MHZ = 167;
	localparam int DBSP_MCLK_MHZ = 100;
	localparam int DBSP_HALF_DIV = 2;
	localparam int DBSP_DIV_CNT_W = 8;
	localparam logic [DBSP_DATA_W-1:0] DBSP_WIDE_USE = 36'hF_FFFF_FFFF;
	localparam logic [DBSP_DATA_W-1:0] DBSP_NARROW_USE = 36'h0_0003_FFFF;
	localparam logic [DBSP_MASK_W-1:0] DBSP_NARROW_LANES_OFF = 4'hC;
endpackage

// file: shared/dbsp_link_if.sv
/*
 link between the memory controller end and the memory device end.
 assumes the bench instantiates it once and hands the two modports to the two ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbsp_link_if;
	import dbsp_pkg::*;
	logic in_clk;
	logic in_clk_n;
	logic out_clk;
	logic out_clk_n;
	logic rd_sel_n;
	logic wr_sel_n;
	logic [DBSP_ADDR_W-1:0] addr_in;
	logic [DBSP_DATA_W-1:0] write_data_in;
	logic [DBSP_MASK_W-1:0] byte_write_mask_n;
	logic dll_enable;
	logic [DBSP_DATA_W-1:0] read_data_out;
	logic read_data_oe;
	logic echo_strobe_pos;
	logic echo_strobe_neg;
	modport dev (
		input in_clk, in_clk_n, out_clk, out_clk_n, rd_sel_n, wr_sel_n, addr_in,
		input write_data_in, byte_write_mask_n, dll_enable,
		output read_data_out, read_data_oe, echo_strobe_pos, echo_strobe_neg
	);
	modport ctrl (
		output in_clk, in_clk_n, out_clk, out_clk_n, rd_sel_n, wr_sel_n, addr_in,
		output write_data_in, byte_write_mask_n, dll_enable,
		input read_data_out, read_data_oe, echo_strobe_pos, echo_strobe_neg
	);
endinterface
`default_nettype wire

// file: core/dbsp_sram_end.sv
/*
 memory device end: command capture on the input clock pair, write buffer with byte masks,
 storage array, ddr read launch on the output clock pair (on the input pair while it is tied high), echo strobes and delay-loop model.
 assumes the controller drives the input pair complementary and meets setup and hold.
*/
`timescale 1ns/1ps
`default_nettype none
module dbsp_sram_end #(
	parameter int WIDE = 1,
	parameter int LOCK_CYC = dbsp_pkg::DBSP_DLL_LOCK_CYC
) (
	input wire logic rst_n,
	dbsp_link_if.dev link,
	output var logic dll_locked,
	output var logic out_timing_from_input
);
	import dbsp_pkg::*;

	localparam logic [DBSP_DATA_W-1:0] USE_BITS = (WIDE != 0) ? DBSP_WIDE_USE : DBSP_NARROW_USE;
	localparam logic [DBSP_MASK_W-1:0] LANES_OFF = (WIDE != 0) ? '0 : DBSP_NARROW_LANES_OFF;
	localparam logic [DBSP_LOCK_CNT_W-1:0] LOCK_LAST = DBSP_LOCK_CNT_W'(LOCK_CYC - 1);

	if (WIDE != 0 && WIDE != 1) begin : g_bad_wide
		$error("WIDE must be 0 or 1");
	end
	if (LOCK_CYC < 1 || LOCK_CYC > (1 << DBSP_LOCK_CNT_W)) begin : g_bad_lock
		$error("LOCK_CYC does not fit the lock counter");
	end

	typedef struct packed {
		logic rd_pend;
		logic [DBSP_ADDR_W-1:0] rd_addr;
		logic wr_pend;
		logic [DBSP_DATA_W-1:0] wd0;
		logic [DBSP_MASK_W-1:0] wm0_n;
		logic [1:0] en_sync;
		logic [DBSP_LOCK_CNT_W-1:0] lock_cnt;
		logic locked;
	} dbsp_kst_type;

	typedef struct packed {
		logic buf_valid;
		logic [DBSP_ADDR_W-1:0] buf_addr;
		logic [DBSP_DATA_W-1:0] buf_d0;
		logic [DBSP_DATA_W-1:0] buf_d1;
		logic [DBSP_MASK_W-1:0] buf_m0_n;
		logic [DBSP_MASK_W-1:0] buf_m1_n;
		logic rd_valid;
		logic [DBSP_DATA_W-1:0] rd_b0;
		logic [DBSP_DATA_W-1:0] rd_b1;
	} dbsp_knst_type;

	typedef struct packed {
		logic [1:0] mode_sync;
		logic hold_valid;
		logic [DBSP_DATA_W-1:0] hold_b0;
		logic [DBSP_DATA_W-1:0] hold_b1;
		logic a_valid;
		logic [DBSP_DATA_W-1:0] a_data;
	} dbsp_opst_type;

	typedef struct packed {
		logic b_valid;
		logic [DBSP_DATA_W-1:0] b_data;
	} dbsp_onst_type;

	dbsp_kst_type kst;
	dbsp_kst_type next_kst;
	dbsp_knst_type knst;
	dbsp_knst_type next_knst;
	dbsp_opst_type opst;
	dbsp_opst_type next_opst;
	dbsp_onst_type onst;
	dbsp_onst_type next_onst;

	// index is {burst address, beat}; the beat bit is the internal low address bit
	logic [DBSP_DATA_W-1:0] mem [2 ** (DBSP_ADDR_W + 1)];

	logic out_tied;
	logic op_clk;
	logic on_clk;

	function automatic logic [DBSP_DATA_W-1:0] merge_bytes(
		input logic [DBSP_DATA_W-1:0] old_d,
		input logic [DBSP_DATA_W-1:0] new_d,
		input logic [DBSP_MASK_W-1:0] mask_n
	);
		logic [DBSP_DATA_W-1:0] res;
		res = old_d;
		for (int i = 0; i < DBSP_MASK_W; i++) begin
			if (!mask_n[i]) begin
				res[i*DBSP_LANE_W +: DBSP_LANE_W] = new_d[i*DBSP_LANE_W +: DBSP_LANE_W];
			end
		end
		return res;
	endfunction

	// input clock true edge: commands, read address, first write beat
	always_comb begin
		next_kst = kst;
		next_kst.rd_pend = !link.rd_sel_n;
		if (!link.rd_sel_n) begin
			next_kst.rd_addr = link.addr_in;
		end
		next_kst.wr_pend = !link.wr_sel_n;
		next_kst.wd0 = link.write_data_in & USE_BITS;
		next_kst.wm0_n = link.byte_write_mask_n | LANES_OFF;
		next_kst.en_sync = {kst.en_sync[0], link.dll_enable};
		if (!kst.en_sync[1]) begin
			next_kst.lock_cnt = '0;
			next_kst.locked = 1'b0;
		end else if (kst.lock_cnt != LOCK_LAST) begin
			next_kst.lock_cnt = kst.lock_cnt + 1'b1;
		end else begin
			next_kst.locked = 1'b1;
		end
	end

	always_ff @(posedge link.in_clk or negedge rst_n) begin
		if (!rst_n) begin
			kst <= '0;
		end else begin
			kst <= next_kst;
		end
	end

	// complement edge: write address, second beat, buffer, array lookup
	always_comb begin
		logic [DBSP_ADDR_W-1:0] waddr;
		logic [DBSP_DATA_W-1:0] wd1;
		logic [DBSP_MASK_W-1:0] wm1_n;
		logic [DBSP_DATA_W-1:0] b0;
		logic [DBSP_DATA_W-1:0] b1;
		waddr = link.addr_in;
		wd1 = link.write_data_in & USE_BITS;
		wm1_n = link.byte_write_mask_n | LANES_OFF;
		b0 = mem[{kst.rd_addr, 1'b0}];
		b1 = mem[{kst.rd_addr, 1'b1}];
		next_knst = knst;
		// older buffered burst first, then a write landing on this same edge
		if (knst.buf_valid && knst.buf_addr == kst.rd_addr) begin
			b0 = merge_bytes(b0, knst.buf_d0, knst.buf_m0_n);
			b1 = merge_bytes(b1, knst.buf_d1, knst.buf_m1_n);
		end
		if (kst.wr_pend && waddr == kst.rd_addr) begin
			b0 = merge_bytes(b0, kst.wd0, kst.wm0_n);
			b1 = merge_bytes(b1, wd1, wm1_n);
		end
		next_knst.rd_valid = kst.rd_pend;
		if (kst.rd_pend) begin
			next_knst.rd_b0 = b0;
			next_knst.rd_b1 = b1;
		end
		if (kst.wr_pend) begin
			next_knst.buf_valid = 1'b1;
			next_knst.buf_addr = waddr;
			next_knst.buf_d0 = kst.wd0;
			next_knst.buf_m0_n = kst.wm0_n;
			next_knst.buf_d1 = wd1;
			next_knst.buf_m1_n = wm1_n;
		end
	end

	always_ff @(posedge link.in_clk_n or negedge rst_n) begin
		if (!rst_n) begin
			knst <= '0;
		end else begin
			knst <= next_knst;
		end
	end

	// the buffered burst reaches the array only when the next write pushes it out
	always_ff @(posedge link.in_clk_n) begin
		if (kst.wr_pend && knst.buf_valid) begin
			mem[{knst.buf_addr, 1'b0}] <= merge_bytes(mem[{knst.buf_addr, 1'b0}], knst.buf_d0, knst.buf_m0_n);
			mem[{knst.buf_addr, 1'b1}] <= merge_bytes(mem[{knst.buf_addr, 1'b1}], knst.buf_d1, knst.buf_m1_n);
		end
	end

	// output pair selection; both high only when tied, never in normal toggling
	assign out_tied = link.out_clk & link.out_clk_n;
	assign op_clk = out_tied ? link.in_clk : link.out_clk;
	assign on_clk = out_tied ? link.in_clk_n : link.out_clk_n;

	// output true edge: loop on launches beat 1 here at 2.0, bypassed launches beat 0 at 1.0
	always_comb begin
		next_opst = opst;
		next_opst.mode_sync = {opst.mode_sync[0], link.dll_enable};
		next_opst.hold_valid = knst.rd_valid;
		next_opst.hold_b0 = knst.rd_b0;
		next_opst.hold_b1 = knst.rd_b1;
		if (opst.mode_sync[1]) begin
			next_opst.a_valid = opst.hold_valid;
			next_opst.a_data = opst.hold_b1;
		end else begin
			next_opst.a_valid = knst.rd_valid;
			next_opst.a_data = knst.rd_b0;
		end
	end

	always_ff @(posedge op_clk or negedge rst_n) begin
		if (!rst_n) begin
			opst <= '0;
		end else begin
			opst <= next_opst;
		end
	end

	// output complement edge: loop on gives beat 0 at 1.5, bypassed gives beat 1 at 1.5
	always_comb begin
		next_onst = onst;
		next_onst.b_valid = opst.hold_valid;
		next_onst.b_data = opst.mode_sync[1] ? opst.hold_b0 : opst.hold_b1;
	end

	always_ff @(posedge on_clk or negedge rst_n) begin
		if (!rst_n) begin
			onst <= '0;
		end else begin
			onst <= next_onst;
		end
	end

	// ddr merge by clock level: the two launch registers take turns on the pins
	always_comb begin
		if (op_clk) begin
			link.read_data_oe = opst.a_valid;
			link.read_data_out = opst.a_valid ? (opst.a_data & USE_BITS) : '0;
		end else begin
			link.read_data_oe = onst.b_valid;
			link.read_data_out = onst.b_valid ? (onst.b_data & USE_BITS) : '0;
		end
	end

	// strobes follow the launching clocks, so they run even with no read in flight
	assign link.echo_strobe_pos = op_clk;
	assign link.echo_strobe_neg = on_clk;

	always_ff @(posedge link.in_clk or negedge rst_n) begin
		if (!rst_n) begin
			dll_locked <= 1'b0;
			out_timing_from_input <= 1'b0;
		end else begin
			dll_locked <= kst.locked;
			out_timing_from_input <= out_tied;
		end
	end
endmodule
`default_nettype wire

// file: core/dbsp_ctrl_end.sv
/*
 memory controller end: divides mclk into the input clock pair, launches read and write
 bursts mid-phase, captures returned beats and hands them to the user.
 assumes user requests are held until acknowledged and the device returns beats in order.
*/
`timescale 1ns/1ps
`default_nettype none
module dbsp_ctrl_end #(
	parameter int WIDE = 1,
	parameter int HALF_DIV = dbsp_pkg::DBSP_HALF_DIV
) (
	input wire logic mclk,
	input wire logic rst_n,
	dbsp_link_if.ctrl link,
	input wire logic dll_on,
	input wire logic tie_out_clk,
	input wire logic rd_req,
	input wire logic [dbsp_pkg::DBSP_ADDR_W-1:0] rd_addr,
	output var logic rd_ack,
	input wire logic wr_req,
	input wire logic [dbsp_pkg::DBSP_ADDR_W-1:0] wr_addr,
	input wire logic [dbsp_pkg::DBSP_DATA_W-1:0] wr_data0,
	input wire logic [dbsp_pkg::DBSP_DATA_W-1:0] wr_data1,
	input wire logic [dbsp_pkg::DBSP_MASK_W-1:0] wr_mask0_n,
	input wire logic [dbsp_pkg::DBSP_MASK_W-1:0] wr_mask1_n,
	output var logic wr_ack,
	output var logic rd_valid,
	output var logic [dbsp_pkg::DBSP_DATA_W-1:0] rd_data0,
	output var logic [dbsp_pkg::DBSP_DATA_W-1:0] rd_data1
);
	import dbsp_pkg::*;

	localparam logic [DBSP_DATA_W-1:0] USE_BITS = (WIDE != 0) ? DBSP_WIDE_USE : DBSP_NARROW_USE;
	localparam logic [DBSP_MASK_W-1:0] LANES_OFF = (WIDE != 0) ? '0 : DBSP_NARROW_LANES_OFF;
	localparam logic [DBSP_DIV_CNT_W-1:0] CNT_LAST = DBSP_DIV_CNT_W'(HALF_DIV - 1);

	// mid-phase launch needs two mclk per half period
	if (HALF_DIV < 2 || HALF_DIV >= (1 << DBSP_DIV_CNT_W)) begin : g_bad_div
		$error("HALF_DIV out of range");
	end
	if (DBSP_MCLK_MHZ / (2 * HALF_DIV) > DBSP_BYPASS_MAX_MHZ) begin : g_bad_freq
		$error("input clock too fast for bypassed loop");
	end

	typedef struct packed {
		logic [DBSP_DIV_CNT_W-1:0] cnt;
		logic k;
		logic k_n;
		logic c;
		logic c_n;
		logic rd_sel_n;
		logic wr_sel_n;
		logic [DBSP_ADDR_W-1:0] addr;
		logic [DBSP_DATA_W-1:0] data;
		logic [DBSP_MASK_W-1:0] mask_n;
		logic [DBSP_ADDR_W-1:0] pend_addr;
		logic [DBSP_DATA_W-1:0] pend_d1;
		logic [DBSP_MASK_W-1:0] pend_m1_n;
		logic dll_en;
		logic rd_ack;
		logic wr_ack;
		logic beat_sel;
		logic rd_valid;
		logic [DBSP_DATA_W-1:0] rd_d0;
		logic [DBSP_DATA_W-1:0] rd_d1;
	} dbsp_cst_type;

	dbsp_cst_type st;
	dbsp_cst_type next_st;

	always_comb begin
		next_st = st;
		next_st.rd_ack = 1'b0;
		next_st.wr_ack = 1'b0;
		next_st.rd_valid = 1'b0;
		next_st.dll_en = dll_on;
		if (st.cnt == CNT_LAST) begin
			next_st.cnt = '0;
			next_st.k = !st.k;
			next_st.k_n = st.k;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
		next_st.c = tie_out_clk ? 1'b1 : next_st.k;
		next_st.c_n = tie_out_clk ? 1'b1 : next_st.k_n;
		// one mclk after a toggle, so both clock edges see stable setup and hold
		if (st.cnt == '0 && !st.k) begin
			next_st.rd_sel_n = !rd_req;
			next_st.wr_sel_n = !wr_req;
			next_st.rd_ack = rd_req;
			next_st.wr_ack = wr_req;
			if (rd_req) begin
				next_st.addr = rd_addr;
			end
			next_st.data = wr_data0 & USE_BITS;
			next_st.mask_n = wr_mask0_n | LANES_OFF;
			next_st.pend_addr = wr_addr;
			next_st.pend_d1 = wr_data1 & USE_BITS;
			next_st.pend_m1_n = wr_mask1_n | LANES_OFF;
		end else if (st.cnt == '0 && st.k) begin
			next_st.rd_sel_n = 1'b1;
			next_st.wr_sel_n = 1'b1;
			next_st.addr = st.pend_addr;
			next_st.data = st.pend_d1;
			next_st.mask_n = st.pend_m1_n;
		end
		// sample at the end of each half period, when the launched beat has settled
		if (st.cnt == CNT_LAST && link.read_data_oe) begin
			if (!st.beat_sel) begin
				next_st.rd_d0 = link.read_data_out & USE_BITS;
				next_st.beat_sel = 1'b1;
			end else begin
				next_st.rd_d1 = link.read_data_out & USE_BITS;
				next_st.beat_sel = 1'b0;
				next_st.rd_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.k_n <= 1'b1;
			st.c_n <= 1'b1;
			st.rd_sel_n <= 1'b1;
			st.wr_sel_n <= 1'b1;
			st.mask_n <= '1;
			st.pend_m1_n <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign link.in_clk = st.k;
	assign link.in_clk_n = st.k_n;
	assign link.out_clk = st.c;
	assign link.out_clk_n = st.c_n;
	assign link.rd_sel_n = st.rd_sel_n;
	assign link.wr_sel_n = st.wr_sel_n;
	assign link.addr_in = st.addr;
	assign link.write_data_in = st.data;
	assign link.byte_write_mask_n = st.mask_n;
	assign link.dll_enable = st.dll_en;
	assign rd_ack = st.rd_ack;
	assign wr_ack = st.wr_ack;
	assign rd_valid = st.rd_valid;
	assign rd_data0 = st.rd_d0;
	assign rd_data1 = st.rd_d1;
endmodule
`default_nettype wire

// file: bench/dbsp_link_properties.sv
/*
 concurrent checks on the link joining the controller end and the memory end.
 assumes mclk at 100 MHz, default half divide of 2 (link period 4 mclk) and the shared async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dbsp_link_properties #(
	parameter int WIDE = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_clk,
	input wire logic in_clk_n,
	input wire logic out_clk,
	input wire logic out_clk_n,
	input wire logic rd_sel_n,
	input wire logic wr_sel_n,
	input wire logic [dbsp_pkg::DBSP_ADDR_W-1:0] addr_in,
	input wire logic [dbsp_pkg::DBSP_DATA_W-1:0] write_data_in,
	input wire logic [dbsp_pkg::DBSP_MASK_W-1:0] byte_write_mask_n,
	input wire logic dll_enable,
	input wire logic [dbsp_pkg::DBSP_DATA_W-1:0] read_data_out,
	input wire logic read_data_oe,
	input wire logic echo_strobe_pos,
	input wire logic echo_strobe_neg
);
	import dbsp_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [4:0] since_rd;
	logic [2:0] tie_run;
	logic [DBSP_DATA_W-1:0] use_mask;
	assign use_mask = (WIDE != 0) ? DBSP_WIDE_USE : DBSP_NARROW_USE;
	// the output mux decodes the tie directly from out_clk and out_clk_n, with no synchroniser; still only judge a settled tie
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			since_rd <= 5'h1F;
			tie_run <= 3'h0;
		end else begin
			since_rd <= !rd_sel_n ? 5'h00 : (since_rd == 5'h1F ? since_rd : since_rd + 5'h01);
			tie_run <= !(out_clk && out_clk_n) ? 3'h0 : (tie_run == 3'h7 ? tie_run : tie_run + 3'h1);
		end
	end
	sequence rd_cmd;
		$rose(in_clk) && !rd_sel_n;
	endsequence
	sequence beats;
		read_data_oe [*4];
	endsequence
	clk_pair_a: assert property (in_clk_n == !in_clk)
		else $error("input clock pair not complementary");
	echo_toggle_a: assert property (1'b1 |-> ##[1:6] !$stable(echo_strobe_pos))
		else $error("echo strobe stopped");
	echo_align_a: assert property (read_data_oe && !$stable(read_data_out) |-> !$stable(echo_strobe_pos))
		else $error("read data moved without an echo edge");
	tie_src_a: assert property (tie_run == 3'h7 |-> echo_strobe_pos == in_clk && echo_strobe_neg == in_clk_n)
		else $error("tied output pair not timed from input pair");
	echo_pair_a: assert property (echo_strobe_neg == !echo_strobe_pos)
		else $error("echo strobe pair not complementary");
	read_only_a: assert property (read_data_oe |-> since_rd < 5'h10)
		else $error("read bus driven without a read");
	idle_zero_a: assert property (!read_data_oe |-> read_data_out == '0)
		else $error("read data not cleared while undriven");
	lane_use_a: assert property (((read_data_out | write_data_in) & ~use_mask) == '0)
		else $error("unused data lanes active");
	dll_lat_a: assert property (rd_cmd and dll_enable |-> !read_data_oe ##6 beats)
		else $error("loop-on read beats misplaced");
	bypass_lat_a: assert property (rd_cmd and !dll_enable |-> ##4 beats)
		else $error("bypass read beats misplaced");
	rd_setup_a: assert property ($rose(in_clk) && !rd_sel_n |-> $stable(addr_in))
		else $error("read address moved at input rise");
	wr_beat0_a: assert property ($rose(in_clk) && !wr_sel_n |-> $stable(write_data_in) && $stable(byte_write_mask_n))
		else $error("first write beat moved at input rise");
	wr_beat1_a: assert property ($rose(in_clk_n) |-> $stable({addr_in, write_data_in, byte_write_mask_n}))
		else $error("write address or second beat moved at complement rise");
endmodule
`default_nettype wire

// file: bench/ddr_burst2_sram_port_tb.sv
/*
 bench for the controller end and memory end joined by the link.
 assumes default half divide; lock count shortened to 8 link edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_burst2_sram_port_tb;
	import dbsp_pkg::*;
	localparam int LOCK = 8;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic dll_on = 1'b1;
	logic tie_out_clk = 1'b1;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic [DBSP_ADDR_W-1:0] rd_addr = '0;
	logic [DBSP_ADDR_W-1:0] wr_addr = '0;
	logic [DBSP_DATA_W-1:0] wr_data0 = '0;
	logic [DBSP_DATA_W-1:0] wr_data1 = '0;
	logic [DBSP_MASK_W-1:0] wr_mask0_n = '1;
	logic [DBSP_MASK_W-1:0] wr_mask1_n = '1;
	logic rd_ack, wr_ack, rd_valid, dll_locked, out_timing_from_input;
	logic [DBSP_DATA_W-1:0] rd_data0, rd_data1;
	logic [DBSP_DATA_W-1:0] exp_mem [int];
	int n_fail = 0;
	int num_checks = 0;
	always #5 mclk = ~mclk;
	dbsp_link_if link ();
	dbsp_ctrl_end dbsp_ctrl_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link.ctrl), .dll_on(dll_on),
		.tie_out_clk(tie_out_clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .wr_req(wr_req),
		.wr_addr(wr_addr), .wr_data0(wr_data0), .wr_data1(wr_data1), .wr_mask0_n(wr_mask0_n),
		.wr_mask1_n(wr_mask1_n), .wr_ack(wr_ack), .rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1));
	dbsp_sram_end #(.LOCK_CYC(LOCK)) dbsp_sram_end_inst (.rst_n(rst_n), .link(link.dev),
		.dll_locked(dll_locked), .out_timing_from_input(out_timing_from_input));
	dbsp_link_properties dbsp_link_properties_inst (.mclk(mclk), .rst_n(rst_n), .in_clk(link.in_clk),
		.in_clk_n(link.in_clk_n), .out_clk(link.out_clk), .out_clk_n(link.out_clk_n), .rd_sel_n(link.rd_sel_n),
		.wr_sel_n(link.wr_sel_n), .addr_in(link.addr_in), .write_data_in(link.write_data_in),
		.byte_write_mask_n(link.byte_write_mask_n), .dll_enable(link.dll_enable),
		.read_data_out(link.read_data_out), .read_data_oe(link.read_data_oe),
		.echo_strobe_pos(link.echo_strobe_pos), .echo_strobe_neg(link.echo_strobe_neg));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [DBSP_DATA_W-1:0] exp, input logic [DBSP_DATA_W-1:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_flag(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic timed_out(input string what);
		chk_flag(what, 1'b1, 1'b0);
		report_and_stop();
	endtask
	// lane-wise merge: a high mask bit keeps the stored lane
	function automatic logic [DBSP_DATA_W-1:0] merge(input logic [DBSP_DATA_W-1:0] old_d,
		input logic [DBSP_DATA_W-1:0] new_d, input logic [DBSP_MASK_W-1:0] m_n);
		logic [DBSP_DATA_W-1:0] r;
		r = old_d;
		for (int i = 0; i < DBSP_MASK_W; i++) begin
			if (!m_n[i]) begin
				r[i*DBSP_LANE_W +: DBSP_LANE_W] = new_d[i*DBSP_LANE_W +: DBSP_LANE_W];
			end
		end
		return r;
	endfunction
	// one slot: optional read and write offered together, each dropped in its ack cycle
	task automatic xfer(input bit do_rd, input bit do_wr, input logic [DBSP_ADDR_W-1:0] ra,
		input logic [DBSP_ADDR_W-1:0] wa, input logic [DBSP_DATA_W-1:0] d0, input logic [DBSP_DATA_W-1:0] d1,
		input logic [DBSP_MASK_W-1:0] m0, input logic [DBSP_MASK_W-1:0] m1);
		int n;
		bit rd_done;
		bit wr_done;
		rd_done = !do_rd;
		wr_done = !do_wr;
		@(posedge mclk);
		rd_addr <= ra;
		wr_addr <= wa;
		wr_data0 <= d0;
		wr_data1 <= d1;
		wr_mask0_n <= m0;
		wr_mask1_n <= m1;
		rd_req <= do_rd;
		wr_req <= do_wr;
		for (n = 0; n < 64 && !(rd_done && wr_done); n++) begin
			@(posedge mclk);
			if (rd_ack === 1'b1) begin
				rd_done = 1'b1;
				rd_req <= 1'b0;
			end
			if (wr_ack === 1'b1) begin
				wr_done = 1'b1;
				wr_req <= 1'b0;
			end
		end
		if (!(rd_done && wr_done)) timed_out("request ack");
		if (do_wr) begin
			exp_mem[int'({wa, 1'b0})] = merge(exp_mem[int'({wa, 1'b0})], d0, m0);
			exp_mem[int'({wa, 1'b1})] = merge(exp_mem[int'({wa, 1'b1})], d1, m1);
		end
		if (do_rd) begin
			for (n = 0; n < 64 && rd_valid !== 1'b1; n++) @(posedge mclk);
			if (rd_valid !== 1'b1) timed_out("read return");
			chk("read beat0", exp_mem[int'({ra, 1'b0})], rd_data0);
			chk("read beat1", exp_mem[int'({ra, 1'b1})], rd_data1);
		end
	endtask
	initial begin
		int n;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk_flag("oe after reset", 1'b0, link.read_data_oe);
		xfer(1'b0, 1'b1, '0, 19'h00010, 36'h1_2345_6789, 36'hA_BCDE_F012, 4'h0, 4'h0);
		xfer(1'b1, 1'b0, 19'h00010, '0, '0, '0, 4'hF, 4'hF);
		xfer(1'b0, 1'b1, '0, 19'h00011, 36'h3_0303_0303, 36'h4_0404_0404, 4'h0, 4'h0);
		xfer(1'b1, 1'b0, 19'h00010, '0, '0, '0, 4'hF, 4'hF);
		xfer(1'b0, 1'b1, '0, 19'h00011, 36'hF_FFFF_FFFF, 36'hE_EEEE_EEEE, 4'h5, 4'hA);
		xfer(1'b1, 1'b1, 19'h00011, 19'h00011, 36'h5_5555_5555, 36'h6_6666_6666, 4'h3, 4'hC);
		xfer(1'b1, 1'b0, 19'h00011, '0, '0, '0, 4'hF, 4'hF);
		// latency follows the loop setting; let the synchroniser settle before the two reads of each setting
		for (int i = 0; i < 4; i++) begin
			dll_on <= i[1];
			tie_out_clk <= i[0];
			repeat (24) @(posedge mclk);
			chk_flag("output pair tied", i[0], out_timing_from_input);
			xfer(1'b1, 1'b0, 19'h00010, '0, '0, '0, 4'hF, 4'hF);
			xfer(1'b1, 1'b0, 19'h00011, '0, '0, '0, 4'hF, 4'hF);
		end
		dll_on <= 1'b0;
		repeat (24) @(posedge mclk);
		chk_flag("lock dropped", 1'b0, dll_locked);
		dll_on <= 1'b1;
		repeat (8) @(posedge mclk);
		chk_flag("lock too early", 1'b0, dll_locked);
		for (n = 0; n < 200 && dll_locked !== 1'b1; n++) @(posedge mclk);
		chk_flag("lock acquired", 1'b1, dll_locked);
		report_and_stop();
	end
endmodule
`default_nettype wire
